/* File: flag_output_and_event_irq.sv */
// Status output pin, event interrupt and flag register logic
`default_nettype none
module flag_output_and_event_irq
    import flag_out_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output var  logic [7:0] reg_rdata,
    // Internal event pulses from timekeeping and supply monitor
    input  wire logic       update_event,
    input  wire logic       wakeup_timer_event,
    input  wire logic       alarm_event,
    input  wire logic       supply_drop_event,
    input  wire logic       low_voltage_event,
    // Event input pin
    input  wire logic       event_input_pin,
    // Open-drain interrupt pin, drive_n low while pulling low
    input  wire logic       irq_output_pin_in,
    output var  logic       irq_output_pin_out,
    output var  logic       irq_output_pin_drive_n,
    // Status output pin, drive_n low while driven
    output var  logic       status_output_pin_out,
    output var  logic       status_output_pin_drive_n,
    // Host interrupt line
    output var  logic       irq
);

    // Register state
    logic [4:0]       flag_q;
    logic [2:0]       ctrl2_q;
    logic [7:0]       ev_setup_q;
    logic             event_trigger_flag_q;
    logic [7:0]       key_q;
    logic [7:0]       status_output_pin_ctrl_q;
    logic [IRQ_N-1:0] irq_stat_q;
    logic [IRQ_N-1:0] irq_mask_q;
    logic             ev_level_q;
    logic             ev_active_q;

    // Decoded strobes
    logic wr_flag;
    logic wr_ctrl2;
    logic wr_setup;
    logic wr_evstat;
    logic wr_key;
    logic wr_sctrl;
    logic wr_istat;
    logic wr_imask;

    assign wr_flag   = reg_write && (reg_addr == ADDR_FLAG);
    assign wr_ctrl2  = reg_write && (reg_addr == ADDR_CTRL2);
    assign wr_setup  = reg_write && (reg_addr == ADDR_EV_SETUP);
    assign wr_evstat = reg_write && (reg_addr == ADDR_EV_STATUS);
    assign wr_key    = reg_write && (reg_addr == ADDR_KEY);
    assign wr_sctrl  = reg_write && (reg_addr == ADDR_STAT_OUT_CTRL);
    assign wr_istat  = reg_write && (reg_addr == ADDR_IRQ_STAT);
    assign wr_imask  = reg_write && (reg_addr == ADDR_IRQ_MASK);

    // Event detection on the active level chosen by the polarity bit
    logic ev_active;
    logic event_detect;
    assign ev_active    = (event_input_pin == ev_setup_q[POS_EHL]);
    assign event_detect = ev_active && !ev_active_q;

    // Flag vector, low to high: supply drop, low voltage, alarm, wakeup, update
    logic [4:0] flag_set;
    logic [4:0] flag_wbit;
    assign flag_set  = {update_event, wakeup_timer_event, alarm_event, low_voltage_event, supply_drop_event};
    assign flag_wbit = {reg_wdata[POS_UPDATE], reg_wdata[POS_WAKEUP], reg_wdata[POS_ALARM], reg_wdata[POS_LOW_VOLT],
                        reg_wdata[POS_SUPPLY_DROP]};

    // Zero clears a flag, one keeps it; a new event wins over the clear
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_N; gi++) begin : g_flag
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    flag_q[gi] <= RST_FLAGS[gi];
                end else if (flag_set[gi]) begin
                    flag_q[gi] <= 1'b1;
                end else if (wr_flag && !flag_wbit[gi]) begin
                    flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Interrupt enables of the other sources
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl2_q <= RST_CTRL2;
        end else if (wr_ctrl2) begin
            ctrl2_q <= {reg_wdata[POS_UIE], reg_wdata[POS_TIE], reg_wdata[POS_AIE]};
        end
    end

    // Event setup register; unused bits except bit 2 kept for readback only, bit 2 always reads zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ev_setup_q <= 8'h00;
        end else if (wr_setup) begin
            ev_setup_q <= {reg_wdata[7:3], 1'b0, reg_wdata[1:0]};
        end
    end

    // Event flag: sticky, no self clear, set beats a zero write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            event_trigger_flag_q <= 1'b0;
        end else if (event_detect) begin
            event_trigger_flag_q <= 1'b1;
        end else if (wr_evstat && !reg_wdata[POS_EV_FLAG]) begin
            event_trigger_flag_q <= 1'b0;
        end
    end

    // Pin level history for edge of the active level
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ev_level_q  <= 1'b0;
            ev_active_q <= 1'b0;
        end else begin
            ev_level_q  <= event_input_pin;
            ev_active_q <= ev_active;
        end
    end

    // Key and status output control
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            key_q       <= RST_KEY;
            status_output_pin_ctrl_q <= RST_STAT_OUT_CTRL;
        end else begin
            if (wr_key) begin
                key_q <= reg_wdata;
            end
            if (wr_sctrl) begin
                status_output_pin_ctrl_q <= {reg_wdata[7:6], 2'b00, reg_wdata[3:0]};
            end
        end
    end

    // Interrupt request OR of the four sources
    logic event_req;
    logic irq_req;
    assign event_req = event_trigger_flag_q && ev_setup_q[POS_EV_IRQ_EN];
    assign irq_req   = event_req
                     || (flag_q[3] && ctrl2_q[1])
                     || (flag_q[2] && ctrl2_q[0])
                     || (flag_q[4] && ctrl2_q[2]);

    // Open-drain pin: drives only low, released otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_output_pin_out     <= 1'b0;
            irq_output_pin_drive_n <= 1'b1;
        end else begin
            irq_output_pin_out     <= 1'b0;
            irq_output_pin_drive_n <= !irq_req;
        end
    end

    // Selected flag per select code
    logic [2:0] fsel;
    logic       sel_flag;
    logic       sel_valid;
    assign fsel = status_output_pin_ctrl_q[POS_FS +: 3];
    always_comb begin
        sel_flag  = 1'b0;
        sel_valid = 1'b1;
        unique case (fsel)
            SEL_WAKEUP:      sel_flag = flag_q[3];
            SEL_ALARM:       sel_flag = flag_q[2];
            SEL_UPDATE:      sel_flag = flag_q[4];
            SEL_EVENT:       sel_flag = event_trigger_flag_q;
            SEL_SUPPLY_DROP: sel_flag = flag_q[0];
            SEL_LOW_VOLT:    sel_flag = flag_q[1];
            default: sel_valid = 1'b0;
        endcase
    end

    // Status output value; direct drive wins and ignores inversion
    logic status_output_pin_value;
    always_comb begin
        if (status_output_pin_ctrl_q[POS_DIRECT_EN]) begin
            status_output_pin_value = status_output_pin_ctrl_q[POS_DIRECT_LVL];
        end else if (!sel_valid) begin
            status_output_pin_value = 1'b0;
        end else begin
            status_output_pin_value = sel_flag ^ status_output_pin_ctrl_q[POS_INVERT];
        end
    end

    // Pin driven only while the key holds the enable code
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_output_pin_out     <= 1'b0;
            status_output_pin_drive_n <= 1'b1;
        end else begin
            status_output_pin_out     <= status_output_pin_value;
            status_output_pin_drive_n <= (key_q != KEY_ENABLE);
        end
    end

    // Host interrupt sources: event, four flags, and pin pulled low
    logic [IRQ_N-1:0] irq_src;
    assign irq_src = {!irq_output_pin_in, flag_set[4:2], supply_drop_event, event_detect};

    // Sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_stat_q <= RST_IRQ;
            irq_mask_q <= RST_IRQ;
        end else begin
            irq_stat_q <= irq_src | (irq_stat_q & ~(wr_istat ? reg_wdata[IRQ_N-1:0] : RST_IRQ));
            if (wr_imask) begin
                irq_mask_q <= reg_wdata[IRQ_N-1:0];
            end
        end
    end

    // Level interrupt, registered
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            ADDR_FLAG: begin
                rd_mux[POS_UPDATE]      = flag_q[4];
                rd_mux[POS_WAKEUP]      = flag_q[3];
                rd_mux[POS_ALARM]       = flag_q[2];
                rd_mux[POS_LOW_VOLT]    = flag_q[1];
                rd_mux[POS_SUPPLY_DROP] = flag_q[0];
            end
            ADDR_CTRL2: begin
                rd_mux[POS_UIE] = ctrl2_q[2];
                rd_mux[POS_TIE] = ctrl2_q[1];
                rd_mux[POS_AIE] = ctrl2_q[0];
            end
            ADDR_EV_SETUP:  rd_mux = ev_setup_q;
            ADDR_EV_STATUS: begin
                rd_mux[POS_EV_FLAG]   = event_trigger_flag_q;
                rd_mux[POS_PIN_LEVEL] = ev_level_q;
            end
            ADDR_KEY:       rd_mux = key_q;
            ADDR_STAT_OUT_CTRL: rd_mux = status_output_pin_ctrl_q;
            ADDR_IRQ_STAT:  rd_mux = {2'b00, irq_stat_q};
            ADDR_IRQ_MASK:  rd_mux = {2'b00, irq_mask_q};
            default:        rd_mux = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

/* File: flag_out_pkg.sv */
// Constants for the status output and event interrupt block
// Summary of operation
// - Event with enable low never pulls interrupt
// - Clearing enable releases held event interrupt
// - Event with enable high pulls interrupt low
// - Event interrupt holds until software clears it
// - Interrupt pin is OR of four requests
// - Monitor bit reads event pin level, read-only
// - Without direct drive, selected flag drives output
// - Supply flags observable on status output pin
// - Software sets status output level directly
// - Code 0Dh shows low-voltage flag inverted
// - Keyed output goes low on low voltage
// - Flag write clears zeros, ones keep flags
// - Direct drive: C0h high, 80h low
// - Select code mapping; other codes force low
// - Invert applies to flags, not direct drive
// - Direct drive enable overrides any flag
`default_nettype none
package flag_out_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_FLAG      = 8'h0E;
    localparam logic [7:0] ADDR_CTRL2     = 8'h0F;
    localparam logic [7:0] ADDR_EV_SETUP  = 8'h17;
    localparam logic [7:0] ADDR_EV_STATUS = 8'h18;
    localparam logic [7:0] ADDR_KEY       = 8'h19;
    localparam logic [7:0] ADDR_STAT_OUT_CTRL = 8'h1A;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h31;
    // Flag register bit positions, index order of the flag vector
    localparam int FLAG_N = 5;
    localparam int POS_SUPPLY_DROP = 0;
    localparam int POS_LOW_VOLT    = 1;
    localparam int POS_ALARM       = 3;
    localparam int POS_WAKEUP      = 4;
    localparam int POS_UPDATE      = 5;
    // Control 2 enable bits
    localparam int POS_AIE = 3;
    localparam int POS_TIE = 4;
    localparam int POS_UIE = 5;
    // Event setup / status bits
    localparam int POS_EV_IRQ_EN = 3;
    localparam int POS_EHL       = 6;
    localparam int POS_PIN_LEVEL = 3;
    localparam int POS_EV_FLAG   = 7;
    // Status output control bits
    localparam int POS_DIRECT_EN  = 7;
    localparam int POS_DIRECT_LVL = 6;
    localparam int POS_INVERT     = 3;
    localparam int POS_FS         = 0;
    // Flag select codes
    localparam logic [2:0] SEL_WAKEUP      = 3'h0;
    localparam logic [2:0] SEL_ALARM       = 3'h1;
    localparam logic [2:0] SEL_UPDATE      = 3'h2;
    localparam logic [2:0] SEL_EVENT       = 3'h7;
    localparam logic [2:0] SEL_SUPPLY_DROP = 3'h4;
    localparam logic [2:0] SEL_LOW_VOLT    = 3'h5;
    // Key code and reset values
    localparam logic [7:0] KEY_ENABLE      = 8'h69;
    localparam logic [7:0] RST_KEY         = 8'h00;
    localparam logic [7:0] RST_STAT_OUT_CTRL = 8'h00;
    localparam logic [4:0] RST_FLAGS       = 5'h00;
    localparam logic [2:0] RST_CTRL2       = 3'h0;
    localparam logic [5:0] RST_IRQ         = 6'h00;
    localparam int IRQ_N = 6;
endpackage
`default_nettype wire

/* File: flag_out_chk.sv */
// Checker for the status output and event interrupt pins
`default_nettype none
module flag_out_chk
    import flag_out_pkg::*;
(
    // Clock, reset and register port
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // Pins
    input wire logic       event_input_pin,
    input wire logic       irq_output_pin_drive_n,
    input wire logic       status_output_pin_out,
    input wire logic       status_output_pin_drive_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       ien_q;
    logic [2:0] src_en_q;
    logic       cfg_wr;
    logic       lvl_bit;
    // Shadow of the interrupt enables, seen from the write strobes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ien_q    <= 1'b0;
            src_en_q <= 3'h0;
        end else if (reg_write && reg_addr == ADDR_EV_SETUP) begin
            ien_q <= reg_wdata[3];
        end else if (reg_write && reg_addr == ADDR_CTRL2) begin
            src_en_q <= reg_wdata[5:3];
        end
    end
    // Writes that may legally release the interrupt pin
    assign cfg_wr  = reg_write && (reg_addr inside {ADDR_EV_SETUP, ADDR_EV_STATUS, ADDR_CTRL2, ADDR_FLAG});
    assign lvl_bit = reg_wdata[6];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_wr(a);
        reg_write && reg_addr == a;
    endsequence
    property p_key_on;
        s_wr(ADDR_KEY) ##0 reg_wdata == KEY_ENABLE |-> ##2 !status_output_pin_drive_n;
    endproperty
    a_key_on: assert property (p_key_on) else $error("status pin not driven after key");
    property p_key_off;
        s_wr(ADDR_KEY) ##0 reg_wdata != KEY_ENABLE |-> ##2 status_output_pin_drive_n;
    endproperty
    a_key_off: assert property (p_key_off) else $error("status pin driven without key");
    property p_direct;
        s_wr(8'h1A) ##0 reg_wdata[7] |-> ##2 status_output_pin_drive_n || status_output_pin_out == $past(lvl_bit, 2);
    endproperty
    a_direct: assert property (p_direct) else $error("direct level not on status pin");
    property p_ien_off;
        s_wr(ADDR_EV_SETUP) ##0 !reg_wdata[3] && src_en_q == 3'h0 |-> ##2 irq_output_pin_drive_n;
    endproperty
    a_ien_off: assert property (p_ien_off) else $error("interrupt pin held after disable");
    property p_flag_clr;
        s_wr(ADDR_EV_STATUS) ##0 !reg_wdata[7] && src_en_q == 3'h0 |-> ##2 irq_output_pin_drive_n;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("interrupt pin held after flag clear");
    property p_ev_pull;
        ien_q && $fell(event_input_pin) && !cfg_wr |-> ##[1:4] !irq_output_pin_drive_n;
    endproperty
    a_ev_pull: assert property (p_ev_pull) else $error("event did not pull interrupt pin");
    property p_ev_hold;
        !irq_output_pin_drive_n && !cfg_wr && !$past(cfg_wr) |=> !irq_output_pin_drive_n;
    endproperty
    a_ev_hold: assert property (p_ev_hold) else $error("interrupt pin released by itself");
    property p_rd_idle;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_ev_quiet;
        !ien_q && src_en_q == 3'h0 |=> irq_output_pin_drive_n;
    endproperty
    a_ev_quiet: assert property (p_ev_quiet) else $error("interrupt pin pulled with all enables off");
    property p_level;
        reg_read && reg_addr == ADDR_EV_STATUS && $stable(event_input_pin) |=> reg_rdata[3] == $past(event_input_pin);
    endproperty
    a_level: assert property (p_level) else $error("monitor bit differs from pin");
endmodule
bind flag_output_and_event_irq flag_out_chk chk (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .event_input_pin, .irq_output_pin_drive_n, .status_output_pin_out, .status_output_pin_drive_n);
`default_nettype wire

/* File: pin_side.sv */
// Far side of the pins: pull-up on the interrupt line, observer on the status pin
`default_nettype none
module pin_side (
    // Clock
    input  wire logic ref_clk,
    // Pins from the block
    input  wire logic irq_output_pin_out,
    input  wire logic irq_output_pin_drive_n,
    input  wire logic status_output_pin_out,
    input  wire logic status_output_pin_drive_n,
    // Levels seen outside
    output var  logic irq_wire,
    output var  logic led_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_q;
    // Undriven status pin has no pull, so it shows the inverse of its last level
    always_ff @(posedge ref_clk) begin
        if (!status_output_pin_drive_n) begin
            last_q <= status_output_pin_out;
        end
    end
    // Pull-up wins whenever nobody pulls the line
    assign irq_wire  = irq_output_pin_drive_n ? 1'b1 : irq_output_pin_out;
    assign led_level = status_output_pin_drive_n ? !last_q : status_output_pin_out;
endmodule
`default_nettype wire

/* File: flag_output_and_event_irq_test.sv */
// Self-checking bench for the status output and event interrupt block
`default_nettype none
module flag_output_and_event_irq_test;
    import flag_out_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk   = 1'b0;
    logic       reset     = 1'b1;
    logic [7:0] reg_addr  = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read  = 1'b0;
    logic [7:0] src       = 8'h00;
    logic       ev_pin    = 1'b1;
    logic [7:0] reg_rdata, c, f;
    logic       irq_out, irq_dn, status_output_pin, status_output_pin_dn, irq, irq_wire, led_level, ef;
    logic [7:0] keys[4]   = '{8'h68, 8'h69, 8'hE9, 8'h00};
    int         miscompares = 0;
    int         checks      = 0;
    int         cyc         = 0;
    flag_output_and_event_irq dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .update_event(src[5]), .wakeup_timer_event(src[4]), .alarm_event(src[3]), .supply_drop_event(src[0]),
        .low_voltage_event(src[1]), .event_input_pin(ev_pin), .irq_output_pin_in(irq_wire),
        .irq_output_pin_out(irq_out), .irq_output_pin_drive_n(irq_dn), .status_output_pin_out(status_output_pin),
        .status_output_pin_drive_n(status_output_pin_dn), .irq);
    pin_side ext (.ref_clk, .irq_output_pin_out(irq_out), .irq_output_pin_drive_n(irq_dn),
        .status_output_pin_out(status_output_pin), .status_output_pin_drive_n(status_output_pin_dn), .irq_wire, .led_level);
    always #4 ref_clk = ~ref_clk;
    // Hang guard, well above the several hundred cycles the run needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 8000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            $display("Error at %0t got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge ref_clk) src <= v;
        @(posedge ref_clk) src <= 8'h00;
    endtask
    // Pin idles high; a dip to low is an event while active level is low
    task automatic evt();
        @(posedge ref_clk) ev_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        ev_pin <= 1'b1;
    endtask
    function automatic logic sx(input logic [7:0] cv, input logic [7:0] fv, input logic e);
        logic v;
        if (cv[7]) return cv[6];
        case (cv[2:0])
            3'h0: v = fv[4];
            3'h1: v = fv[3];
            3'h2: v = fv[5];
            3'h7: v = e;
            3'h4: v = fv[0];
            3'h5: v = fv[1];
            default: return 1'b0;
        endcase
        return v ^ cv[3];
    endfunction
    initial begin
        void'($urandom(39));
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        rd(ADDR_FLAG, 8'h00);
        rd(ADDR_KEY, 8'h00);
        rd(8'h1A, 8'h00);
        rd(8'h55, 8'h00);
        rd(ADDR_EV_STATUS, 8'h08);
        // Event with interrupt disabled sets only the flag
        @(posedge ref_clk) ev_pin <= 1'b0;
        tick(4);
        chk(8'(irq_wire), 8'h01);
        rd(ADDR_EV_STATUS, 8'h80);
        wr(ADDR_EV_STATUS, 8'hFF);
        @(posedge ref_clk) ev_pin <= 1'b1;
        tick(4);
        rd(ADDR_EV_STATUS, 8'h88);
        wr(ADDR_EV_STATUS, 8'h00);
        // Enabled event pulls the line and keeps it until software acts
        wr(ADDR_EV_SETUP, 8'h08);
        evt();
        tick(2);
        chk(8'(irq_wire), 8'h00);
        tick(30);
        chk(8'(irq_wire), 8'h00);
        wr(ADDR_EV_SETUP, 8'h00);
        tick(2);
        chk(8'(irq_wire), 8'h01);
        wr(ADDR_EV_SETUP, 8'h08);
        tick(2);
        chk(8'(irq_wire), 8'h00);
        wr(ADDR_EV_STATUS, 8'h00);
        tick(2);
        chk(8'(irq_wire), 8'h01);
        // Another source holds the line with the event enable off
        wr(ADDR_EV_SETUP, 8'h00);
        wr(ADDR_CTRL2, 8'h10);
        pulse(8'h10);
        tick(3);
        chk(8'(irq_wire), 8'h00);
        wr(ADDR_FLAG, 8'h00);
        tick(2);
        chk(8'(irq_wire), 8'h01);
        wr(ADDR_CTRL2, 8'h00);
        // Host interrupt: sticky status, mask, write-one clear
        wr(ADDR_IRQ_STAT, 8'hFF);
        wr(ADDR_IRQ_MASK, 8'h02);
        pulse(8'h01);
        tick(2);
        chk(8'(irq), 8'h01);
        rd(ADDR_IRQ_STAT, 8'h02);
        wr(ADDR_IRQ_MASK, 8'h00);
        tick(2);
        chk(8'(irq), 8'h00);
        wr(ADDR_IRQ_MASK, 8'h02);
        tick(2);
        chk(8'(irq), 8'h01);
        wr(ADDR_IRQ_STAT, 8'h02);
        tick(2);
        chk(8'(irq), 8'h00);
        // Low-voltage flag shown inverted, selective flag clear
        pulse(8'h3B);
        wr(ADDR_FLAG, 8'h39);
        rd(ADDR_FLAG, 8'h39);
        wr(8'h1A, 8'h0D);
        wr(ADDR_KEY, KEY_ENABLE);
        tick(2);
        chk(8'(status_output_pin_dn), 8'h00);
        chk(8'(led_level), 8'h01);
        pulse(8'h02);
        tick(2);
        chk(8'(led_level), 8'h00);
        wr(ADDR_FLAG, 8'h39);
        tick(2);
        chk(8'(led_level), 8'h01);
        // Direct drive corners, every select code both ways, then random
        for (int k = 0; k < 36; k++) begin
            c  = k < 4 ? {1'b1, k[0], 2'b00, k[1], 3'h0} : k < 20 ? {4'h0, 4'(k - 4)} : 8'($urandom) & 8'hCF;
            f  = 8'($urandom) & 8'h3B;
            ef = 1'($urandom);
            wr(ADDR_FLAG, 8'h00);
            wr(ADDR_EV_STATUS, 8'h00);
            pulse(f);
            if (ef) evt();
            wr(8'h1A, c);
            tick(2);
            chk(8'(led_level), 8'(sx(c, f, ef)));
            rd(ADDR_FLAG, f);
        end
        // Only the enable code drives the status pin
        foreach (keys[i]) begin
            wr(ADDR_KEY, keys[i]);
            tick(2);
            chk(8'(status_output_pin_dn), 8'(keys[i] != KEY_ENABLE));
        end
        // Active-high event level: rising pin is the event
        @(posedge ref_clk) ev_pin <= 1'b0;
        wr(ADDR_EV_SETUP, 8'h48);
        wr(ADDR_EV_STATUS, 8'h00);
        tick(2);
        chk(8'(irq_wire), 8'h01);
        @(posedge ref_clk) ev_pin <= 1'b1;
        tick(3);
        chk(8'(irq_wire), 8'h00);
        rd(ADDR_EV_STATUS, 8'h88);
        rd(ADDR_EV_SETUP, 8'h48);
        conclude();
    end
endmodule
`default_nettype wire
